// [rmts_downstream.sv]
`timescale 1ns/1ps
module rmts_downstream import rmts_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_valid,
  input wire rmts_word_t tx_word,
  input wire rmts_src_t tx_source,
  output logic got_ff,
  output logic [37:0] entry_ff
);
  // The station latches every word; the link has no back-pressure.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      got_ff <= 1'h0;
      entry_ff <= '0;
    end else begin
      got_ff <= tx_valid;
      entry_ff <= {tx_source, tx_word};
    end
  end
endmodule : rmts_downstream

// [rmts_map.svh]
`ifndef RMTS_MAP_SVH
`define RMTS_MAP_SVH
`define RMTS_MTU_WORDS 11'h200
`define RMTS_Q_DEPTH 11'h400
`define RMTS_HDR_WORDS 11'h004
`define RMTS_IDLE_LAST 3'h3
`define RMTS_IDLE_DATA 32'hA5A5A5A5
`define RMTS_CLS_A 2'h0
`define RMTS_SHP_IDLE 0
`define RMTS_SHP_CTL 1
`define RMTS_SHP_CLSA 2
`define RMTS_SHP_DOWN 3
`define RMTS_ADR_CONFIG 6'h00
`define RMTS_ADR_STATUS 6'h01
`define RMTS_SHP_FIRST 3'h2
`define RMTS_SHP_LAST 3'h5
`define RMTS_FLD_RATE 3'h0
`define RMTS_FLD_DEBIT 3'h1
`define RMTS_FLD_UINT 3'h2
`define RMTS_FLD_LO 3'h3
`define RMTS_FLD_HI 3'h4
`define RMTS_FLD_CREDIT 3'h5
`define RMTS_CFG_HFM 0
`define RMTS_CFG_DUAL 1
`define RMTS_CFG_RST 2'h0
`define RMTS_RATE_RST 16'h0001
`define RMTS_DEBIT_RST 16'h0040
`define RMTS_UINT_RST 16'h0000
`define RMTS_LO_RST 24'h000000
`define RMTS_HI_RST 24'h001000
`define RMTS_CREDIT_FLOOR 26'h3FFFE00
`endif

// [rmts_pkg.sv]
package rmts_pkg;
  typedef struct packed {
    logic eof;
    logic [1:0] cls;
    logic [31:0] data;
  } rmts_word_t;
  typedef enum logic [2:0] {ST_FIRST, ST_CHECK, ST_NEEDY, ST_STAGE, ST_SECOND, ST_FINAL} rmts_state_t;
  typedef enum logic [2:0] {SRC_NONE, SRC_IDLE, SRC_CTL, SRC_PTQ, SRC_STG, SRC_STQ} rmts_src_t;

  function automatic logic [31:0] rmts_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : rmts_merge
endpackage : rmts_pkg

// [rmts_selector.sv]
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "rmts_map.svh"
module rmts_selector import rmts_pkg::*; (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic RX_VALID,
  input wire rmts_word_t RX_WORD,
  output logic RX_READY,
  input wire logic CONTROL_FRAME_PRESENT,
  input wire logic [10:0] CONTROL_FRAME_LENGTH,
  input wire logic CTL_VALID,
  input wire rmts_word_t CTL_WORD,
  output logic CTL_GRANT,
  input wire logic STAGE_HEADER_PRESENT,
  input wire logic STAGE_FRAME_PRESENT,
  input wire logic STG_VALID,
  input wire rmts_word_t STG_WORD,
  output logic STG_GRANT,
  output logic TX_VALID,
  output rmts_word_t TX_WORD,
  output rmts_src_t TX_SOURCE,
  output logic CONTROL_SEND_PERMIT,
  output logic CLASSA_SEND_PERMIT,
  output logic DOWNSTREAM_SUSTAIN_PERMIT
);
  logic [1:0] cfg_ff;
  logic [15:0] rate_ff [4];
  logic [15:0] debit_ff [4];
  logic [15:0] uint_ff [4];
  logic [23:0] lo_ff [4];
  logic [23:0] hi_ff [4];
  logic signed [23:0] credit_w [4];
  logic [3:0] permit_w;
  logic [3:0] debit_ev;
  logic wb_ack_ff;
  logic [31:0] wb_dat_ff;
  rmts_state_t state_ff;
  rmts_state_t nxt_state;
  rmts_src_t src_ff;
  rmts_src_t nxt_src;
  logic hfm_ff;
  logic dual_ff;
  logic [2:0] idle_cnt_ff;
  logic rx_ready_ff;
  logic ctl_grant_ff;
  logic stg_grant_ff;
  logic tx_valid_ff;
  rmts_word_t tx_word_ff;
  rmts_src_t tx_src_ff;
  logic ctl_permit_ff;
  logic clsa_permit_ff;
  logic down_permit_ff;
  rmts_word_t head_w [2];
  logic [10:0] cnt_w [2];
  logic [10:0] frm_w [2];
  logic [10:0] free_w [2];
  logic [1:0] push;
  logic [1:0] pop;

  // Bus decode.
  wire wb_req = WB_CYC_I && WB_STB_I && !wb_ack_ff;
  wire [5:0] widx = WB_ADR_I[7:2];
  wire wb_wr = wb_req && WB_WE_I;
  wire shp_hit = (widx[5:3] >= `RMTS_SHP_FIRST) && (widx[5:3] <= `RMTS_SHP_LAST);
  wire [1:0] shp_idx = 2'(widx[5:3] - `RMTS_SHP_FIRST);
  wire [2:0] fld = widx[2:0];
  wire cfg_hit = widx == `RMTS_ADR_CONFIG;
  wire sta_hit = widx == `RMTS_ADR_STATUS;
  wire [31:0] shp_rd =
    (fld == `RMTS_FLD_RATE) ? {16'h0000, rate_ff[shp_idx]} :
    (fld == `RMTS_FLD_DEBIT) ? {16'h0000, debit_ff[shp_idx]} :
    (fld == `RMTS_FLD_UINT) ? {16'h0000, uint_ff[shp_idx]} :
    (fld == `RMTS_FLD_LO) ? {8'h00, lo_ff[shp_idx]} :
    (fld == `RMTS_FLD_HI) ? {8'h00, hi_ff[shp_idx]} :
    (fld == `RMTS_FLD_CREDIT) ? {{8{credit_w[shp_idx][23]}}, credit_w[shp_idx]} : 32'h00000000;
  wire [31:0] rd_data =
    cfg_hit ? {30'h00000000, cfg_ff} :
    sta_hit ? {permit_w, tx_src_ff, state_ff, cnt_w[1], cnt_w[0]} :
    shp_hit ? shp_rd : 32'h00000000;
  // Shaper writes merge the byte lanes into the current field value.
  wire [31:0] shp_new = rmts_merge(shp_rd, WB_DAT_I, WB_SEL_I);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h00000000;
    end else if (CE) begin
      wb_ack_ff <= wb_req;
      wb_dat_ff <= wb_req ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg_ff <= `RMTS_CFG_RST;
    end else if (CE && wb_wr && cfg_hit) begin
      cfg_ff <= 2'(rmts_merge({30'h00000000, cfg_ff}, WB_DAT_I, WB_SEL_I));
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int s = 0; s < 4; s++) begin
        rate_ff[s] <= `RMTS_RATE_RST;
        debit_ff[s] <= `RMTS_DEBIT_RST;
        uint_ff[s] <= `RMTS_UINT_RST;
        lo_ff[s] <= `RMTS_LO_RST;
        hi_ff[s] <= `RMTS_HI_RST;
      end
    end else if (CE && wb_wr && shp_hit) begin
      unique case (fld)
        `RMTS_FLD_RATE: begin
          rate_ff[shp_idx] <= shp_new[15:0];
        end
        `RMTS_FLD_DEBIT: begin
          debit_ff[shp_idx] <= shp_new[15:0];
        end
        `RMTS_FLD_UINT: begin
          uint_ff[shp_idx] <= shp_new[15:0];
        end
        `RMTS_FLD_LO: begin
          lo_ff[shp_idx] <= shp_new[23:0];
        end
        `RMTS_FLD_HI: begin
          hi_ff[shp_idx] <= shp_new[23:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Credit shapers: one algorithm, four parameter sets.
  for (genvar s = 0; s < 4; s++) begin : g_shp
    logic signed [23:0] credit_ff;
    logic [15:0] ucnt_ff;
    wire tick = ucnt_ff >= uint_ff[s];
    wire signed [25:0] add_v = tick ? $signed({10'h000, rate_ff[s]}) : 26'sh0000000;
    wire signed [25:0] sub_v = debit_ev[s] ? $signed({10'h000, debit_ff[s]}) : 26'sh0000000;
    wire signed [25:0] sum = $signed({{2{credit_ff[23]}}, credit_ff}) + add_v - sub_v;
    wire signed [25:0] cap = $signed({2'b00, hi_ff[s]});
    wire signed [25:0] nxt_credit =
      (sum > cap) ? cap :
      (sum < $signed(`RMTS_CREDIT_FLOOR)) ? $signed(`RMTS_CREDIT_FLOOR) : sum;
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        credit_ff <= 24'sh000000;
        ucnt_ff <= 16'h0000;
      end else if (CE) begin
        credit_ff <= 24'(nxt_credit);
        ucnt_ff <= tick ? 16'h0000 : 16'(ucnt_ff + 16'h0001);
      end
    end
    assign credit_w[s] = credit_ff;
    assign permit_w[s] = (credit_ff >= $signed(lo_ff[s])) &&
                         ($signed({{2{credit_ff[23]}}, credit_ff}) > $signed(`RMTS_CREDIT_FLOOR));
  end

  // Transit queues: 0 is primary, 1 is secondary.
  wire rx_take = RX_VALID && rx_ready_ff;
  wire to_stq = cfg_ff[`RMTS_CFG_DUAL] && (RX_WORD.cls != `RMTS_CLS_A);
  assign push[0] = CE && rx_take && !to_stq;
  assign push[1] = CE && rx_take && to_stq;

  for (genvar q = 0; q < 2; q++) begin : g_q
    rmts_word_t mem [1024];
    logic [9:0] wr_ff;
    logic [9:0] rd_ff;
    logic [10:0] cnt_ff;
    logic [10:0] frm_ff;
    wire pin = push[q] && RX_WORD.eof;
    wire pout = pop[q] && mem[rd_ff].eof;
    always_ff @(posedge CLK) begin
      if (push[q]) begin
        mem[wr_ff] <= RX_WORD;
      end
    end
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        wr_ff <= 10'h000;
        rd_ff <= 10'h000;
        cnt_ff <= 11'h000;
        frm_ff <= 11'h000;
      end else begin
        if (push[q]) wr_ff <= 10'(wr_ff + 10'h001);
        if (pop[q]) rd_ff <= 10'(rd_ff + 10'h001);
        cnt_ff <= 11'(cnt_ff + {10'h000, push[q]} - {10'h000, pop[q]});
        frm_ff <= 11'(frm_ff + {10'h000, pin} - {10'h000, pout});
      end
    end
    assign head_w[q] = mem[rd_ff];
    assign cnt_w[q] = cnt_ff;
    assign frm_w[q] = frm_ff;
    assign free_w[q] = 11'(`RMTS_Q_DEPTH - cnt_ff);
  end

  // Selection.
  wire ptq_hdr = (cnt_w[0] >= `RMTS_HDR_WORDS) || (frm_w[0] != 11'h000);
  wire stq_hdr = (cnt_w[1] >= `RMTS_HDR_WORDS) || (frm_w[1] != 11'h000);
  wire ptq_ok = hfm_ff ? ptq_hdr : (frm_w[0] != 11'h000);
  wire stq_ok = hfm_ff ? stq_hdr : (frm_w[1] != 11'h000);
  wire stg_ok = hfm_ff ? STAGE_HEADER_PRESENT : STAGE_FRAME_PRESENT;
  wire ptq_empty = cnt_w[0] == 11'h000;
  wire ctl_permit = permit_w[`RMTS_SHP_CTL] && permit_w[`RMTS_SHP_CLSA];
  wire ctl_skip = !CONTROL_FRAME_PRESENT || !ctl_permit ||
                  (CONTROL_FRAME_LENGTH > free_w[0]) ||
                  (cfg_ff[`RMTS_CFG_DUAL] && (CONTROL_FRAME_LENGTH > free_w[1]));
  wire idle_eof = idle_cnt_ff == `RMTS_IDLE_LAST;
  wire rmts_word_t idle_word = '{eof: idle_eof, cls: `RMTS_CLS_A, data: `RMTS_IDLE_DATA};
  wire src_avail =
    (src_ff == SRC_IDLE) ||
    ((src_ff == SRC_CTL) && CTL_VALID && ctl_grant_ff) ||
    ((src_ff == SRC_PTQ) && !ptq_empty) ||
    ((src_ff == SRC_STG) && STG_VALID && stg_grant_ff) ||
    ((src_ff == SRC_STQ) && (cnt_w[1] != 11'h000));
  wire rmts_word_t src_word =
    (src_ff == SRC_IDLE) ? idle_word :
    (src_ff == SRC_CTL) ? CTL_WORD :
    (src_ff == SRC_PTQ) ? head_w[0] :
    (src_ff == SRC_STG) ? STG_WORD : head_w[1];
  wire in_final = state_ff == ST_FINAL;
  wire send = in_final && src_avail;
  wire send_eof = send && src_word.eof;
  assign pop[0] = CE && send && (src_ff == SRC_PTQ);
  assign pop[1] = CE && send && (src_ff == SRC_STQ);
  assign debit_ev[`RMTS_SHP_IDLE] = CE && send_eof && (src_ff == SRC_IDLE);
  assign debit_ev[`RMTS_SHP_CTL] = CE && send_eof && (src_ff == SRC_CTL);
  assign debit_ev[`RMTS_SHP_CLSA] = CE && send_eof && (src_ff != SRC_IDLE) &&
                                     (src_word.cls == `RMTS_CLS_A);
  assign debit_ev[`RMTS_SHP_DOWN] = CE && send_eof && (src_ff != SRC_IDLE) &&
                                     (src_word.cls != `RMTS_CLS_A);

  always_comb begin
    nxt_state = state_ff;
    nxt_src = src_ff;
    unique case (state_ff)
      ST_FIRST: begin
        if (permit_w[`RMTS_SHP_IDLE]) begin
          nxt_src = SRC_IDLE;
          nxt_state = ST_FINAL;
        end else if (ctl_skip) begin
          nxt_state = ST_CHECK;
        end else begin
          nxt_src = SRC_CTL;
          nxt_state = ST_FINAL;
        end
      end
      ST_CHECK: begin
        if (ptq_ok) begin
          nxt_src = SRC_PTQ;
          nxt_state = ST_FINAL;
        end else begin
          nxt_state = dual_ff ? ST_NEEDY : ST_STAGE;
        end
      end
      ST_NEEDY: begin
        if ((free_w[1] < `RMTS_MTU_WORDS) && ptq_empty && (cnt_w[1] != 11'h000)) begin
          nxt_src = SRC_STQ;
          nxt_state = ST_FINAL;
        end else begin
          nxt_state = ST_STAGE;
        end
      end
      ST_STAGE: begin
        if (stg_ok) begin
          nxt_src = SRC_STG;
          nxt_state = ST_FINAL;
        end else if (dual_ff) begin
          nxt_state = ST_SECOND;
        end else begin
          nxt_src = SRC_NONE;
          nxt_state = ST_FINAL;
        end
      end
      ST_SECOND: begin
        nxt_state = ST_FINAL;
        if (permit_w[`RMTS_SHP_DOWN] && ptq_empty && stq_ok) begin
          nxt_src = SRC_STQ;
        end else begin
          nxt_src = SRC_NONE;
        end
      end
      ST_FINAL: begin
        if ((src_ff == SRC_NONE) || send_eof) begin
          nxt_state = ST_FIRST;
          nxt_src = SRC_NONE;
        end
      end
      // Unused state codes fall back to the first state.
      default: begin
        nxt_state = ST_FIRST;
        nxt_src = SRC_NONE;
      end
    endcase
  end

  // Forward mode and arrangement are frozen while a selection runs.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_ff <= ST_FIRST;
      src_ff <= SRC_NONE;
      hfm_ff <= 1'b0;
      dual_ff <= 1'b0;
    end else if (CE) begin
      state_ff <= nxt_state;
      src_ff <= nxt_src;
      if (state_ff == ST_FIRST) begin
        hfm_ff <= cfg_ff[`RMTS_CFG_HFM];
        dual_ff <= cfg_ff[`RMTS_CFG_DUAL];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      idle_cnt_ff <= 3'h0;
    end else if (CE && send && (src_ff == SRC_IDLE)) begin
      idle_cnt_ff <= idle_eof ? 3'h0 : 3'(idle_cnt_ff + 3'h1);
    end
  end

  // Transmit stage: one word per cycle, no back-pressure.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_valid_ff <= 1'b0;
      tx_word_ff <= '0;
      tx_src_ff <= SRC_NONE;
    end else if (CE) begin
      tx_valid_ff <= send;
      tx_word_ff <= send ? src_word : '0;
      tx_src_ff <= send ? src_ff : SRC_NONE;
    end
  end

  // Ready, grants and permits leave the block registered.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_ready_ff <= 1'b0;
      ctl_grant_ff <= 1'b0;
      stg_grant_ff <= 1'b0;
      ctl_permit_ff <= 1'b0;
      clsa_permit_ff <= 1'b0;
      down_permit_ff <= 1'b0;
    end else if (CE) begin
      rx_ready_ff <= (free_w[0] > 11'h002) && (free_w[1] > 11'h002);
      ctl_grant_ff <= (nxt_state == ST_FINAL) && (nxt_src == SRC_CTL);
      stg_grant_ff <= (nxt_state == ST_FINAL) && (nxt_src == SRC_STG);
      ctl_permit_ff <= ctl_permit;
      clsa_permit_ff <= permit_w[`RMTS_SHP_CLSA];
      down_permit_ff <= permit_w[`RMTS_SHP_DOWN];
    end
  end

  assign WB_ACK_O = wb_ack_ff;
  assign WB_DAT_O = wb_dat_ff;
  assign RX_READY = rx_ready_ff;
  assign CTL_GRANT = ctl_grant_ff;
  assign STG_GRANT = stg_grant_ff;
  assign TX_VALID = tx_valid_ff;
  assign TX_WORD = tx_word_ff;
  assign TX_SOURCE = tx_src_ff;
  assign CONTROL_SEND_PERMIT = ctl_permit_ff;
  assign CLASSA_SEND_PERMIT = clsa_permit_ff;
  assign DOWNSTREAM_SUSTAIN_PERMIT = down_permit_ff;
endmodule : rmts_selector

// [rmts_selector_asserts.sv]
`timescale 1ns/1ps
`include "rmts_map.svh"
module rmts_selector_asserts import rmts_pkg::*; (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic TX_VALID,
  input wire rmts_word_t TX_WORD,
  input wire rmts_src_t TX_SOURCE,
  input wire logic CTL_GRANT,
  input wire logic CTL_VALID,
  input wire rmts_word_t CTL_WORD,
  input wire logic STG_GRANT,
  input wire logic STG_VALID,
  input wire rmts_word_t STG_WORD,
  input wire logic CONTROL_FRAME_PRESENT,
  input wire logic [10:0] CONTROL_FRAME_LENGTH,
  input wire logic STAGE_HEADER_PRESENT,
  input wire logic STAGE_FRAME_PRESENT
);
  wire logic idle_v = TX_VALID && TX_SOURCE == SRC_IDLE;
  wire logic idle_mid = idle_v && !TX_WORD.eof;
  wire logic stg_rdy = STAGE_HEADER_PRESENT || STAGE_FRAME_PRESENT;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_idle_data: assert property (idle_v |-> TX_WORD.data == `RMTS_IDLE_DATA)
    else $error("Idle word carries wrong data.");
  a_idle_len: assert property (idle_v && !$past(idle_mid) |->
    idle_mid [*3] ##1 (idle_v && TX_WORD.eof))
    else $error("Idle frame is not four words.");
  a_ctl_copy: assert property (CTL_GRANT && CTL_VALID && CE |=>
    TX_VALID && TX_SOURCE == SRC_CTL && TX_WORD == $past(CTL_WORD))
    else $error("Control word not forwarded.");
  a_ctl_start: assert property ($rose(CTL_GRANT) |->
    $past(CONTROL_FRAME_PRESENT) && $past(CONTROL_FRAME_LENGTH) <= `RMTS_Q_DEPTH)
    else $error("Control granted while it should be skipped.");
  a_ctl_drop: assert property (CTL_GRANT && CTL_VALID && CTL_WORD.eof |-> ##[1:2] !CTL_GRANT)
    else $error("Control grant held after frame end.");
  a_stg_copy: assert property (STG_GRANT && STG_VALID && CE |=>
    TX_VALID && TX_SOURCE == SRC_STG && TX_WORD == $past(STG_WORD))
    else $error("Stage word not forwarded.");
  a_stg_start: assert property ($rose(STG_GRANT) |-> $past(stg_rdy))
    else $error("Stage granted with nothing present.");
  a_grant_excl: assert property (!(CTL_GRANT && STG_GRANT))
    else $error("Two sources granted at once.");
  a_src_hold: assert property (TX_VALID && !TX_WORD.eof |=>
    !TX_VALID || TX_SOURCE == $past(TX_SOURCE))
    else $error("Source changed inside a frame.");
endmodule : rmts_selector_asserts

// [rmts_selector_test.sv]
`timescale 1ns/1ps
`include "rmts_map.svh"
module rmts_selector_test import rmts_pkg::*;;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, rx_rdy, ctl_g, stg_g, tx_v, got, csp, asp, dsp;
  logic rx_v = 1'h0;
  logic cfp = 1'h0;
  logic ctl_v = 1'h0;
  logic shp = 1'h0;
  logic stg_v = 1'h0;
  logic big = 1'h0;
  logic [10:0] cfl = 11'h000;
  rmts_word_t rx_w = '0;
  rmts_word_t ctl_w = '0;
  rmts_word_t stg_w = '0;
  rmts_word_t tx_w;
  rmts_src_t tx_s;
  logic [37:0] got_e;
  rmts_word_t ctl_q[$];
  rmts_word_t stg_q[$];
  logic [37:0] exp_q[$];
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  rmts_selector dut (.CLK(clk), .RST(rst), .CE(1'h1), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .RX_VALID(rx_v), .RX_WORD(rx_w), .RX_READY(rx_rdy),
    .CONTROL_FRAME_PRESENT(cfp), .CONTROL_FRAME_LENGTH(cfl), .CTL_VALID(ctl_v),
    .CTL_WORD(ctl_w), .CTL_GRANT(ctl_g), .STAGE_HEADER_PRESENT(shp),
    .STAGE_FRAME_PRESENT(shp), .STG_VALID(stg_v), .STG_WORD(stg_w), .STG_GRANT(stg_g),
    .TX_VALID(tx_v), .TX_WORD(tx_w), .TX_SOURCE(tx_s), .CONTROL_SEND_PERMIT(csp),
    .CLASSA_SEND_PERMIT(asp), .DOWNSTREAM_SUSTAIN_PERMIT(dsp));

  rmts_downstream link (.clk(clk), .rst(rst), .tx_valid(tx_v), .tx_word(tx_w),
    .tx_source(tx_s), .got_ff(got), .entry_ff(got_e));

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [37:0] g, input logic [37:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, g, e);
    end
  endtask : chk

  // A read compares its data with d; a write sends d.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'h1) @(posedge clk);
    if (!w) chk(38'(rdat), 38'(d));
    cyc <= 1'h0;
    @(posedge clk);
  endtask : wb

  task automatic frame(input int dst, input rmts_src_t s, input logic [1:0] c, input int n);
    rmts_word_t w;
    for (int i = 0; i < n; i++) begin
      w.eof = i == n - 1;
      w.cls = c;
      w.data = $urandom;
      exp_q.push_back({s, w});
      if (dst == 1) ctl_q.push_back(w);
      else if (dst == 2) stg_q.push_back(w);
      else begin
        rx_v <= 1'h1;
        rx_w <= w;
        @(posedge clk);
        while (rx_rdy !== 1'h1) @(posedge clk);
      end
    end
    if (dst == 0) begin
      rx_v <= 1'h0;
      rx_w <= ~w;
      @(posedge clk);
    end
  endtask : frame

  task automatic drain;
    while (exp_q.size() != 0) @(posedge clk);
  endtask : drain

  always @(posedge clk) begin
    if (ctl_g && ctl_v) begin
      void'(ctl_q.pop_front());
    end
    ctl_v <= ctl_q.size() != 0;
    ctl_w <= ctl_q.size() != 0 ? ctl_q[0] : ~ctl_w;
    cfp <= ctl_q.size() != 0;
    cfl <= big ? 11'h7FF : 11'(ctl_q.size());
  end

  always @(posedge clk) begin
    if (stg_g && stg_v) begin
      void'(stg_q.pop_front());
    end
    stg_v <= stg_q.size() != 0;
    stg_w <= stg_q.size() != 0 ? stg_q[0] : ~stg_w;
    shp <= stg_q.size() != 0;
  end

  always @(posedge clk) begin
    if (got && got_e[37:35] !== SRC_IDLE) begin
      if (exp_q.size() == 0) chk(got_e, ~got_e);
      else chk(got_e, exp_q.pop_front());
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(58408));
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      wb(1'h0, 8'(8'h40 + 32'h20 * k), 32'(`RMTS_RATE_RST));
      wb(1'h0, 8'(8'h44 + 32'h20 * k), 32'(`RMTS_DEBIT_RST));
      wb(1'h0, 8'(8'h48 + 32'h20 * k), 32'(`RMTS_UINT_RST));
      wb(1'h0, 8'(8'h50 + 32'h20 * k), 32'(`RMTS_HI_RST));
    end
    wb(1'h1, 8'hC0, 32'hFFFFFFFF);
    wb(1'h0, 8'hC0, 32'h0);
    wb(1'h0, 8'h00, 32'h0);
    chk(38'(asp), 38'h1);
    chk(38'(dsp), 38'h1);
    wb(1'h1, 8'h4C, 32'h7FFFFF);
    wb(1'h0, 8'h4C, 32'h7FFFFF);
    repeat (12) @(posedge clk);
    repeat (3) frame(0, SRC_PTQ, 2'($urandom_range(2)), 2 + $urandom_range(6));
    drain();
    repeat (400) @(posedge clk);
    frame(0, SRC_PTQ, 2'h1, 20);
    while (!(got && got_e[37:35] === SRC_PTQ)) @(posedge clk);
    @(negedge clk);
    frame(1, SRC_CTL, 2'h0, 3);
    frame(2, SRC_STG, 2'h2, 4);
    drain();
    for (int m = 0; m < 2; m++) begin
      if (m == 0) wb(1'h1, 8'h6C, 32'h7FFFFF);
      if (m == 0) chk(38'(csp), 38'h0);
      @(negedge clk);
      big = m == 1;
      frame(2, SRC_STG, 2'h2, 3);
      frame(1, SRC_CTL, 2'h0, 2);
      while (stg_q.size() != 0 || stg_g !== 1'h0) @(posedge clk);
      if (m == 0) wb(1'h1, 8'h6C, 32'h0);
      if (m == 0) chk(38'(csp), 38'h1);
      @(negedge clk);
      big = 1'h0;
      drain();
    end
    wb(1'h1, 8'h00, 32'h2);
    frame(0, SRC_PTQ, 2'h0, 5);
    frame(0, SRC_STQ, 2'h1, 4);
    frame(0, SRC_STQ, 2'h2, 3);
    drain();
    wb(1'h1, 8'h00, 32'h3);
    wb(1'h0, 8'h00, 32'h3);
    frame(0, SRC_PTQ, 2'h0, 9);
    frame(0, SRC_STQ, 2'h2, 6);
    drain();
    wrap_up();
  end
endmodule : rmts_selector_test

bind rmts_selector rmts_selector_asserts chk_i (.CLK, .RST, .CE, .TX_VALID, .TX_WORD,
  .TX_SOURCE, .CTL_GRANT, .CTL_VALID, .CTL_WORD, .STG_GRANT, .STG_VALID, .STG_WORD,
  .CONTROL_FRAME_PRESENT, .CONTROL_FRAME_LENGTH, .STAGE_HEADER_PRESENT,
  .STAGE_FRAME_PRESENT);
